// ===== pkg/smd_pkg.sv
// Purpose: constants for the system memory address latch and decode
// Assumes: one clock MCLK, asynchronous active-high reset RST
// Notes: bit positions index the upper address byte and port A
//
// Functional notes
// - an 8-bit latch captures the low address byte when the strobe rises.
// - the latched low byte feeds memory address inputs, not the muxed bus.
// - address bit A15 chooses upper-half or lower-half memory decoding.
// - both half selects stay inactive (high) unless a memory cycle runs.
// - upper decoder gives four active-low enables from A14 and A13.
// - lower decoder gives four active-low enables from port bits 4 and 0.
// - discrete logic forms one chip enable per memory device.
// - port bits 1 and 2 drive the boot ROM top address lines as page.
// - code ROM 32 kbyte bank chosen by the bank-select decoder output.
// - mass-store ROM A14 is held high; only its upper half is used.
// - the 32 kbyte application RAM is selectable on the system bus.
// - the 32 kbyte capture buffer RAM is selectable on the system bus.
package smd_pkg;
    // *****************************************************************
    // reset values
    // *****************************************************************
    localparam logic [7:0] ADDR_LO_RST = 8'h00;
    localparam logic ALE_RST = 1'b0;
    // *****************************************************************
    // positions within the upper address byte (A8 is bit 0)
    // *****************************************************************
    localparam int HALF_BIT = 7;
    localparam int DEC_HI_BIT = 6;
    localparam int DEC_LO_BIT = 5;
    localparam int WIN_BIT = 6;
    // *****************************************************************
    // positions within peripheral port A
    // *****************************************************************
    localparam int PA_ZERO = 0;
    localparam int PA_PAGE_LO = 1;
    localparam int PA_PAGE_HI = 2;
    localparam int PA_RAM_SEL = 3;
    localparam int PA_FOUR = 4;
    // *****************************************************************
    // lower decoder output use
    // *****************************************************************
    localparam int LO_PAGE = 0;
    localparam int LO_BANK0 = 1;
    localparam int LO_BANK1 = 2;
    localparam int LO_MASS = 3;
    // *****************************************************************
    // fixed levels
    // *****************************************************************
    localparam logic MASS_A14_LVL = 1'b1;
    localparam logic [3:0] DEC_IDLE = 4'hf;
endpackage

// ===== src/smd_memory_decode.sv
// Purpose: low address demultiplex and memory chip-select decode
// Assumes: bus, strobe and port inputs synchronous to MCLK
// Notes: decode is combinational; latched address comes from flops
module smd_memory_decode #(
    parameter int LATCH_W = 8
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [LATCH_W-1:0] MUXED_ADDR_DATA_BUS,
    input wire logic ALE,
    input wire logic [7:0] ADDR_HI,
    input wire logic MEM_IO_N,
    input wire logic [7:0] PORT_A,
    output logic [LATCH_W-1:0] SYS_ADDR_LO,
    output logic HALF_ENABLE_A_N,
    output logic HALF_ENABLE_B_N,
    output logic [3:0] UPPER_EN_N,
    output logic [3:0] LOWER_EN_N,
    output logic BANK_SELECT_N,
    output logic PAGE_SELECT_LOW,
    output logic PAGE_SELECT_HIGH,
    output logic MASS_ROM_A14,
    output logic PAGE_ROM_CE_N,
    output logic BANK_ROM_CE_N,
    output logic MASS_ROM_CE_N,
    output logic APP_RAM_CE_N,
    output logic CAP_RAM_CE_N
);

    // *****************************************************************
    // parameter check
    // *****************************************************************
    if (LATCH_W < 1 || LATCH_W > 16) begin : g_bad_width
        $error("LATCH_W must lie between 1 and 16");
    end

    // *****************************************************************
    // address latch
    // *****************************************************************
    logic [LATCH_W-1:0] addr_lo_r;
    logic [LATCH_W-1:0] addr_lo_nxt;
    logic ale_r;
    logic ale_nxt;
    logic ale_rise;

    // strobe is compared with its last sample, so the rise is caught on the first MCLK edge that sees it high
    // a held strobe captures once; a repeat needs the strobe low first
    always_comb begin
        ale_nxt = ALE;
        ale_rise = ALE & ~ale_r;
        addr_lo_nxt = addr_lo_r;
        if (ale_rise) begin
            addr_lo_nxt = MUXED_ADDR_DATA_BUS;
        end
        // otherwise held through the data phase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            addr_lo_r <= LATCH_W'(smd_pkg::ADDR_LO_RST);
            ale_r <= smd_pkg::ALE_RST;
        end else begin
            addr_lo_r <= addr_lo_nxt;
            ale_r <= ale_nxt;
        end
    end

    // separate driver keeps memory address off the muxed lines
    assign SYS_ADDR_LO = addr_lo_r;

    // *****************************************************************
    // half select
    // *****************************************************************
    logic mem_cycle;
    logic half_a;
    logic half_b;

    assign mem_cycle = ~MEM_IO_N;
    assign half_a = mem_cycle & ADDR_HI[smd_pkg::HALF_BIT];
    assign half_b = mem_cycle & ~ADDR_HI[smd_pkg::HALF_BIT];
    assign HALF_ENABLE_A_N = ~half_a;
    assign HALF_ENABLE_B_N = ~half_b;

    // *****************************************************************
    // dual two-to-four decoder
    // *****************************************************************
    logic [1:0] up_sel;
    logic [1:0] lo_sel;

    assign up_sel = {ADDR_HI[smd_pkg::DEC_HI_BIT],
                     ADDR_HI[smd_pkg::DEC_LO_BIT]};
    assign lo_sel = {PORT_A[smd_pkg::PA_FOUR], PORT_A[smd_pkg::PA_ZERO]};

    for (genvar i = 0; i < 4; i++) begin : g_dec
        assign UPPER_EN_N[i] = ~(half_a & (up_sel == 2'(i)));
        assign LOWER_EN_N[i] = ~(half_b & (lo_sel == 2'(i)));
    end

    // *****************************************************************
    // discrete chip-enable logic
    // *****************************************************************
    logic upper_any;
    logic win_low;

    assign upper_any = ~(&UPPER_EN_N);
    // page and mass ROMs both see a 16 kbyte window of the lower half
    assign win_low = ~ADDR_HI[smd_pkg::WIN_BIT];

    // each enable comes from distinct decoder outputs; the bank ROM takes two
    assign PAGE_ROM_CE_N = ~(~LOWER_EN_N[smd_pkg::LO_PAGE] &
                             win_low);
    assign BANK_ROM_CE_N = LOWER_EN_N[smd_pkg::LO_BANK0] &
                           LOWER_EN_N[smd_pkg::LO_BANK1];
    assign MASS_ROM_CE_N = ~(~LOWER_EN_N[smd_pkg::LO_MASS] &
                             win_low);

    // both RAMs share the whole upper half; port A picks which
    assign APP_RAM_CE_N = ~(upper_any &
                            ~PORT_A[smd_pkg::PA_RAM_SEL]);
    assign CAP_RAM_CE_N = ~(upper_any &
                            PORT_A[smd_pkg::PA_RAM_SEL]);

    // *****************************************************************
    // paging and banking
    // *****************************************************************
    assign PAGE_SELECT_LOW = PORT_A[smd_pkg::PA_PAGE_LO];
    assign PAGE_SELECT_HIGH = PORT_A[smd_pkg::PA_PAGE_HI];
    // low selects bank 0; the top ROM address line follows it
    assign BANK_SELECT_N = LOWER_EN_N[smd_pkg::LO_BANK0];
    // lower half of that ROM is unused space
    assign MASS_ROM_A14 = smd_pkg::MASS_A14_LVL;

    // *****************************************************************
    // assertions
    // *****************************************************************
    logic [4:0] ce_act;
    assign ce_act = ~{PAGE_ROM_CE_N, BANK_ROM_CE_N, MASS_ROM_CE_N,
                      APP_RAM_CE_N, CAP_RAM_CE_N};

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    a_latch_capture: assert property (
        (ALE && !ale_r) |=>
            SYS_ADDR_LO == $past(MUXED_ADDR_DATA_BUS))
        else $error("low address not captured on strobe rise");

    a_bus_isolated: assert property (
        ($changed(MUXED_ADDR_DATA_BUS) && !(ALE && !ale_r)) |=>
            $stable(SYS_ADDR_LO))
        else $error("memory address followed the muxed bus");

    a_half_choice: assert property (
        !MEM_IO_N |->
            (HALF_ENABLE_A_N == !ADDR_HI[smd_pkg::HALF_BIT]) &&
            (HALF_ENABLE_B_N == ADDR_HI[smd_pkg::HALF_BIT]))
        else $error("half select does not follow A15");

    a_io_blocks_mem: assert property (
        MEM_IO_N |->
            HALF_ENABLE_A_N && HALF_ENABLE_B_N &&
            (UPPER_EN_N == smd_pkg::DEC_IDLE) &&
            (LOWER_EN_N == smd_pkg::DEC_IDLE) && (ce_act == 5'h0_0))
        else $error("memory enabled during an io cycle");

    a_upper_decode: assert property (
        !HALF_ENABLE_A_N |->
            $onehot(~UPPER_EN_N) &&
            !UPPER_EN_N[{ADDR_HI[smd_pkg::DEC_HI_BIT],
                         ADDR_HI[smd_pkg::DEC_LO_BIT]}])
        else $error("upper decoder output wrong");

    a_upper_idle: assert property (
        HALF_ENABLE_A_N |-> UPPER_EN_N == smd_pkg::DEC_IDLE)
        else $error("upper decoder active without its half select");

    a_lower_decode: assert property (
        !HALF_ENABLE_B_N |->
            $onehot(~LOWER_EN_N) &&
            !LOWER_EN_N[{PORT_A[smd_pkg::PA_FOUR],
                         PORT_A[smd_pkg::PA_ZERO]}])
        else $error("lower decoder output wrong");

    a_device_enables: assert property (
        (ce_act != 5'h0_0) |->
            (!HALF_ENABLE_A_N || !HALF_ENABLE_B_N))
        else $error("chip enable without a half select");

    a_page_lines: assert property (
        (PAGE_SELECT_LOW == PORT_A[smd_pkg::PA_PAGE_LO]) &&
        (PAGE_SELECT_HIGH == PORT_A[smd_pkg::PA_PAGE_HI]))
        else $error("page lines do not follow port A");

    a_bank_choice: assert property (
        !BANK_ROM_CE_N |->
            (BANK_SELECT_N == PORT_A[smd_pkg::PA_FOUR]))
        else $error("bank select does not match decoded bank");

    a_mass_upper: assert property (
        MASS_ROM_A14 and
        (!MASS_ROM_CE_N |-> !ADDR_HI[smd_pkg::HALF_BIT]))
        else $error("mass ROM upper half not forced");

    a_app_ram_sel: assert property (
        (!MEM_IO_N && ADDR_HI[smd_pkg::HALF_BIT] &&
         !PORT_A[smd_pkg::PA_RAM_SEL]) |-> !APP_RAM_CE_N)
        else $error("application RAM not selected");

    a_cap_ram_sel: assert property (
        (!MEM_IO_N && ADDR_HI[smd_pkg::HALF_BIT] &&
         PORT_A[smd_pkg::PA_RAM_SEL]) |-> !CAP_RAM_CE_N)
        else $error("capture RAM not selected");

    a_single_device: assert property (
        $onehot0(ce_act))
        else $error("two memory devices enabled at once");

    a_addr_hold: assert property (
        (ALE && !ale_r) ##1 (!(ALE && !ale_r))[*3] |->
            SYS_ADDR_LO == $past(SYS_ADDR_LO, 2))
        else $error("latched address moved between strobes");

    a_strobe_track: assert property (
        1'b1 |=> ale_r == $past(ALE))
        else $error("strobe history does not follow the pin");

    a_held_strobe: assert property (
        (ALE && ale_r) |=> $stable(SYS_ADDR_LO))
        else $error("held strobe captured a second time");

    a_half_exclusive: assert property (
        HALF_ENABLE_A_N || HALF_ENABLE_B_N)
        else $error("both memory halves enabled at once");

    a_lower_idle: assert property (
        HALF_ENABLE_B_N |-> LOWER_EN_N == smd_pkg::DEC_IDLE)
        else $error("lower decoder active without its half select");

    a_bank_idle: assert property (
        HALF_ENABLE_B_N |-> BANK_SELECT_N)
        else $error("bank select driven without a lower half cycle");

    // *****************************************************************
    // chip enable map
    // *****************************************************************
    // each ROM enable checked against its own decode term

    a_page_rom_ce: assert property (
        !PAGE_ROM_CE_N ==
            (!LOWER_EN_N[smd_pkg::LO_PAGE] && !ADDR_HI[smd_pkg::WIN_BIT]))
        else $error("page ROM enable wrong");

    a_bank_rom_ce: assert property (
        !BANK_ROM_CE_N == (!LOWER_EN_N[smd_pkg::LO_BANK0] ||
                           !LOWER_EN_N[smd_pkg::LO_BANK1]))
        else $error("bank ROM enable wrong");

    a_mass_rom_ce: assert property (
        !MASS_ROM_CE_N ==
            (!LOWER_EN_N[smd_pkg::LO_MASS] && !ADDR_HI[smd_pkg::WIN_BIT]))
        else $error("mass ROM enable wrong");

    a_rom_lower_only: assert property (
        (!PAGE_ROM_CE_N || !BANK_ROM_CE_N || !MASS_ROM_CE_N) |->
            !MEM_IO_N && !ADDR_HI[smd_pkg::HALF_BIT])
        else $error("ROM enabled outside the lower half");

    a_ram_upper_only: assert property (
        (!APP_RAM_CE_N || !CAP_RAM_CE_N) |->
            !MEM_IO_N && ADDR_HI[smd_pkg::HALF_BIT])
        else $error("RAM enabled outside the upper half");

    a_app_ram_off: assert property (
        PORT_A[smd_pkg::PA_RAM_SEL] |-> APP_RAM_CE_N)
        else $error("application RAM enabled while capture RAM picked");

    a_cap_ram_off: assert property (
        !PORT_A[smd_pkg::PA_RAM_SEL] |-> CAP_RAM_CE_N)
        else $error("capture RAM enabled while application RAM picked");

    a_ram_pick: assert property (
        APP_RAM_CE_N || CAP_RAM_CE_N)
        else $error("both RAMs enabled at once");

    // *****************************************************************
    // main scenarios
    // *****************************************************************
    c_app_access: cover property (
        (ALE && !ale_r) ##1 !APP_RAM_CE_N);
    c_cap_access: cover property (
        (ALE && !ale_r) ##1 !CAP_RAM_CE_N);
    c_bank_one: cover property (
        !BANK_ROM_CE_N && BANK_SELECT_N);
    c_page_three: cover property (
        !PAGE_ROM_CE_N && PAGE_SELECT_LOW && PAGE_SELECT_HIGH);
    c_mass_access: cover property (
        !MASS_ROM_CE_N && MASS_ROM_A14);

endmodule

// ===== tb/smd_cpu_model.sv
// Purpose: processor side of the memory decode, runs bus cycles
// Assumes: outputs change 1 ns after the rising MCLK edge
// Notes: a released bus shows the address XOR 5a, then its inverse, never the address
module smd_cpu_model (
    input wire logic mclk,
    output logic ale,
    output logic [7:0] bus,
    output logic [7:0] addr_hi,
    output logic mem_io_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ale = 1'b0;
        bus = 8'h00;
        addr_hi = 8'h00;
        mem_io_n = 1'b1;
    end
    // ****************************************************************
    // one bus cycle; hold keeps the strobe up for extra cycles
    // ****************************************************************
    task automatic bus_cycle(input logic [15:0] a, input logic mio,
            input int hold);
        @(posedge mclk);
        #1;
        ale = 1'b1;
        bus = a[7:0];
        addr_hi = a[15:8];
        mem_io_n = mio;
        repeat (hold) begin
            @(posedge mclk);
            #1;
            bus = ~bus;
        end
        @(posedge mclk);
        #1;
        ale = 1'b0;
        bus = a[7:0] ^ 8'h5a;
        @(posedge mclk);
        #1;
        bus = ~bus;
    endtask
endmodule

// ===== tb/system_memory_decode_tb_top.sv
// Purpose: self-checking bench for the memory latch and decode
// Assumes: decode is combinational, latch answers one cycle late
// Notes: seed 40; corner tables first, random cycles after
module system_memory_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] port_a = 8'h00;
    wire logic ale, mem_io_n, ha_n, hb_n, bank_n, pg_lo, pg_hi, m_a14;
    wire logic [7:0] bus, addr_hi, sys_lo;
    wire logic [3:0] up_n, lo_n;
    wire logic [4:0] ce_n;
    int error_cnt = 0;
    int total_checks = 0;
    always #10 mclk = ~mclk;
    smd_cpu_model smd_cpu_model_inst (.mclk(mclk), .ale(ale), .bus(bus),
        .addr_hi(addr_hi), .mem_io_n(mem_io_n));
    smd_memory_decode #(.LATCH_W(8)) smd_memory_decode_inst (
        .MCLK(mclk), .RST(rst), .MUXED_ADDR_DATA_BUS(bus), .ALE(ale),
        .ADDR_HI(addr_hi), .MEM_IO_N(mem_io_n), .PORT_A(port_a),
        .SYS_ADDR_LO(sys_lo), .HALF_ENABLE_A_N(ha_n),
        .HALF_ENABLE_B_N(hb_n), .UPPER_EN_N(up_n), .LOWER_EN_N(lo_n),
        .BANK_SELECT_N(bank_n), .PAGE_SELECT_LOW(pg_lo),
        .PAGE_SELECT_HIGH(pg_hi), .MASS_ROM_A14(m_a14),
        .PAGE_ROM_CE_N(ce_n[4]), .BANK_ROM_CE_N(ce_n[3]),
        .MASS_ROM_CE_N(ce_n[2]), .APP_RAM_CE_N(ce_n[1]),
        .CAP_RAM_CE_N(ce_n[0]));
    // ****************************************************************
    // expected decode: halves, decoders, then chip enables
    // ****************************************************************
    function automatic logic [18:0] exp_dec(logic [7:0] hi, logic mio,
            logic [7:0] pa);
        logic mem, a15;
        logic [3:0] up, lo;
        mem = ~mio;
        a15 = hi[7];
        up = (mem & a15) ? ~(4'h1 << hi[6:5]) : 4'hf;
        lo = (mem & ~a15) ? ~(4'h1 << {pa[4], pa[0]}) : 4'hf;
        return {~(mem & a15), ~(mem & ~a15), up, lo, lo[1], pa[1], pa[2],
            1'b1, lo[0] | hi[6], lo[1] & lo[2], lo[3] | hi[6],
            ~(mem & a15 & ~pa[3]), ~(mem & a15 & pa[3])};
    endfunction
    task automatic check(string name, logic [18:0] seen, logic [18:0] e);
        total_checks++;
        if (seen !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, e, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************************************************************
    // one cycle, then decode, latch and exclusivity checks
    // ****************************************************************
    task automatic run(logic [15:0] a, logic mio, logic [7:0] pa,
            int hold);
        logic [18:0] e;
        @(posedge mclk);
        #1;
        port_a = pa;
        smd_cpu_model_inst.bus_cycle(a, mio, hold);
        #1;
        e = exp_dec(a[15:8], mio, pa);
        check("halves", {9'h000, ha_n, hb_n, up_n, lo_n},
            {9'h000, e[18:9]});
        check("enables", {10'h000, bank_n, pg_lo, pg_hi, m_a14, ce_n},
            {10'h000, e[8:0]});
        check("low address", {11'h000, sys_lo},
            {11'h000, a[7:0]});
        check("one enable", 19'($countones(~ce_n) <= 1),
            19'h1);
    endtask
    initial begin
        void'($urandom(40));
        repeat (20) @(posedge mclk);
        #1;
        check("reset address", {11'h000, sys_lo}, 19'h0);
        rst = 1'b0;
        // upper decoder, both RAM picks
        for (int i = 0; i < 4; i++) begin
            run({1'b1, 2'(i), 13'(i * 37)}, 1'b0, {4'h0, i[0], 3'h0}, 0);
        end
        // lower decoder, with and without the A14 window
        for (int i = 0; i < 8; i++) begin
            run({1'b0, i[2], 14'(i)}, 1'b0, {3'h0, i[1], 3'h0, i[0]}, 0);
        end
        // io cycles must select nothing
        run(16'hc0a5, 1'b1, 8'h08, 0);
        run(16'h2011, 1'b1, 8'h00, 0);
        // strobe held high: only the first byte counts
        run(16'h4a3c, 1'b0, 8'h16, 3);
        for (int i = 0; i < 60; i++) begin
            run(16'($urandom), 1'($urandom), 8'($urandom), $urandom % 2);
        end
        // reset in mid-run clears the latch, then a cycle still lands
        @(posedge mclk);
        #1;
        rst = 1'b1;
        #1;
        check("mid reset", {11'h000, sys_lo}, 19'h0);
        @(posedge mclk);
        #1;
        rst = 1'b0;
        run(16'h5a69, 1'b0, 8'h08, 0);
        summarize();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        summarize();
    end
endmodule
